// >>> inc/rcc_pkg.sv
// Purpose: constants for the read channel control register block
// Assumes: one 32-bit register at offset 0x00
// Notes: field positions and reset values live here
package rcc_pkg;
  localparam logic [7:0] RCC_CTRL_OFFSET = 8'h00;
  localparam int RCC_BIT_RUN = 0;
  localparam int RCC_BIT_RSVD_ONE = 1;
  localparam int RCC_BIT_SOFT_RESET = 2;
  localparam int RCC_BIT_FIXED_ADDR = 3;
  localparam int RCC_BIT_CPL_EN = 12;
  localparam int RCC_BIT_TMO_EN = 13;
  localparam int RCC_BIT_FLT_EN = 14;
  localparam int RCC_THR_LSB = 16;
  localparam int RCC_TMO_LSB = 24;
  localparam logic [7:0] RCC_THR_RESET = 8'h01;
  localparam logic [7:0] RCC_TMO_RESET = 8'h00;
  // soft reset held this many cycles plus one after the engine and descriptor queue report quiet
  localparam logic [3:0] RCC_SRST_HOLD = 4'h4;
  typedef enum logic [1:0] {
    RCC_HALTED = 2'b00,
    RCC_RUNNING = 2'b01,
    RCC_STOPPING = 2'b11
  } rcc_run_t;
endpackage : rcc_pkg

// >>> verification/read_channel_control_reg_bench.sv
// Purpose: self-checking bench for the read channel control register block
// Assumes: one instance per descriptor mode setting, engine inputs driven here
// Notes: inputs move 1 ns after the rising edge; table rows first, awkward cases after
`timescale 1ns/100ps
`default_nettype none
module read_channel_control_reg_bench
  import rcc_pkg::*;
;
  logic clock, sys_rst, regWrite, regRead;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, rdVal;
  logic engineActive, descUpdatePending, channelError, completionEvent;
  logic packetEnd, packetStart, timeoutTick, faultIrqFlag, otherSoftReset;
  logic runEnable, haltedFlag, fixedAddrMode, softResetOut;
  logic completionIrqFlag, timeoutIrqFlag, channelIrq;
  logic plainCplFlag, plainTmoFlag, plainIrq;
  int err_total, cmp_count, n;
  // table rows: write value, expected read back
  logic [31:0] rowIn [4] = '{32'hFFFFFFFB, 32'h00000000, 32'h05003008, 32'h00034000};
  logic [31:0] rowOut [4] = '{32'hFFFF700B, 32'h00FF0002, 32'h05FF300A, 32'h00034002};

  rcc_read_channel_control #(.DESCRIPTOR_MODE_PARAM(1'b1)) DUT (.clock(clock), .sys_rst(sys_rst),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .engineActive(engineActive), .descUpdatePending(descUpdatePending), .channelError(channelError),
    .completionEvent(completionEvent), .packetEnd(packetEnd), .packetStart(packetStart),
    .timeoutTick(timeoutTick), .faultIrqFlag(faultIrqFlag), .otherSoftReset(otherSoftReset),
    .runEnable(runEnable), .haltedFlag(haltedFlag), .fixedAddrMode(fixedAddrMode),
    .softResetOut(softResetOut), .completionIrqFlag(completionIrqFlag), .timeoutIrqFlag(timeoutIrqFlag),
    .channelIrq(channelIrq));

  // same stimulus, built without descriptor mode
  rcc_read_channel_control #(.DESCRIPTOR_MODE_PARAM(1'b0)) DUT_PLAIN (.clock(clock), .sys_rst(sys_rst),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(),
    .engineActive(engineActive), .descUpdatePending(descUpdatePending), .channelError(channelError),
    .completionEvent(completionEvent), .packetEnd(packetEnd), .packetStart(packetStart),
    .timeoutTick(timeoutTick), .faultIrqFlag(faultIrqFlag), .otherSoftReset(otherSoftReset),
    .runEnable(), .haltedFlag(), .fixedAddrMode(), .softResetOut(), .completionIrqFlag(plainCplFlag),
    .timeoutIrqFlag(plainTmoFlag), .channelIrq(plainIrq));

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk32

  task automatic chk1(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  task automatic wr(input logic [31:0] d);
    @(posedge clock);
    #1 regWrite = 1'b1;
    regAddr = RCC_CTRL_OFFSET;
    regWdata = d;
    @(posedge clock);
    #1 regWrite = 1'b0;
  endtask : wr

  // registered read data lands on the edge that takes the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    #1 regRead = 1'b1;
    regAddr = a;
    @(posedge clock);
    #1 regRead = 1'b0;
    rdVal = regRdata;
  endtask : rd

  // one-cycle pulse on a chosen engine input
  task automatic pulse(input int which);
    @(posedge clock);
    #1;
    case (which)
      0: channelError = 1'b1;
      1: completionEvent = 1'b1;
      2: packetEnd = 1'b1;
      3: timeoutTick = 1'b1;
      5: packetStart = 1'b1;
      default: otherSoftReset = 1'b1;
    endcase
    @(posedge clock);
    #1 {channelError, completionEvent, packetEnd, packetStart, timeoutTick, otherSoftReset} = 6'h00;
  endtask : pulse

  task automatic wrap_up();
    if (err_total == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // ****************************************
  // clock, watchdog, main sequence
  // ****************************************
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // whole run is about a hundred and ten cycles, so this only cuts a hang
  initial
  begin
    repeat (3000) @(posedge clock);
    err_total++;
    wrap_up();
  end

  initial
  begin
    {sys_rst, regWrite, regRead, engineActive, descUpdatePending, faultIrqFlag} = 6'h20;
    {channelError, completionEvent, packetEnd, packetStart, timeoutTick, otherSoftReset} = 6'h00;
    regAddr = 8'h00;
    regWdata = 32'h00000000;
    err_total = 0;
    cmp_count = 0;
    repeat (6) @(posedge clock);
    #1 sys_rst = 1'b0;
    chk1("halted", 1'b1, haltedFlag);
    rd(RCC_CTRL_OFFSET);
    chk32("reset", 32'h00010002, rdVal);
    for (int i = 0; i < 4; i++)
    begin
      wr(rowIn[i]);
      rd(RCC_CTRL_OFFSET);
      chk32("row", rowOut[i], rdVal);
      chk1("fixed", rowOut[i][3], fixedAddrMode);
    end
    wr(32'h00010001);
    chk1("run", 1'b1, runEnable);
    engineActive = 1'b1;
    for (n = 0; n < 10 && haltedFlag !== 1'b0; n++) #40;
    chk1("started", 1'b0, haltedFlag);
    descUpdatePending = 1'b1;
    wr(32'h00010000);
    engineActive = 1'b0;
    #200;
    chk1("draining", 1'b0, haltedFlag);
    descUpdatePending = 1'b0;
    for (n = 0; n < 10 && haltedFlag !== 1'b1; n++) #40;
    chk1("stopped", 1'b1, haltedFlag);
    wr(32'h00010001);
    pulse(0);
    rd(RCC_CTRL_OFFSET);
    chk1("errstop", 1'b0, rdVal[0]);
    chk1("errrun", 1'b0, runEnable);
    wr(32'h00030000);
    faultIrqFlag = 1'b1;
    #1 chk1("faultoff", 1'b0, channelIrq);
    wr(32'h00034000);
    chk1("faulton", 1'b1, channelIrq);
    faultIrqFlag = 1'b0;
    wr(32'h00021000);
    pulse(1);
    chk1("cpl1", 1'b0, completionIrqFlag);
    chk1("plaincpl", 1'b1, plainCplFlag);
    pulse(1);
    for (n = 0; n < 4 && completionIrqFlag !== 1'b1; n++) #40;
    chk1("cpl2", 1'b1, completionIrqFlag);
    chk1("cplirq", 1'b1, channelIrq);
    wr(32'h02012000);
    pulse(2);
    pulse(3);
    chk1("tmo1", 1'b0, timeoutIrqFlag);
    pulse(3);
    for (n = 0; n < 4 && timeoutIrqFlag !== 1'b1; n++) #40;
    chk1("tmo2", 1'b1, timeoutIrqFlag);
    chk1("tmoirq", 1'b1, channelIrq);
    chk1("plaintmo", 1'b0, plainTmoFlag);
    chk1("plainirq", 1'b0, plainIrq);
    engineActive = 1'b1;
    wr(32'h00000004);
    #40 chk1("srst", 1'b1, softResetOut);
    #320 chk1("srstbusy", 1'b1, softResetOut);
    engineActive = 1'b0;
    for (n = 0; n < 20 && softResetOut !== 1'b0; n++) #40;
    chk1("srstdone", 1'b0, softResetOut);
    chk1("cplclr", 1'b0, completionIrqFlag);
    chk1("tmoclr", 1'b0, timeoutIrqFlag);
    rd(RCC_CTRL_OFFSET);
    chk32("afterrst", 32'h00010002, rdVal);
    // a new packet cancels an armed timer
    wr(32'h02002000);
    pulse(2);
    pulse(5);
    pulse(3);
    pulse(3);
    pulse(3);
    chk1("tmocancel", 1'b0, timeoutIrqFlag);
    // zero timeout keeps the timer off
    wr(32'h00002000);
    pulse(2);
    pulse(3);
    pulse(3);
    chk1("tmozero", 1'b0, timeoutIrqFlag);
    pulse(4);
    chk1("othersrst", 1'b1, softResetOut);
    for (n = 0; n < 20 && softResetOut !== 1'b0; n++) #40;
    rd(8'h04);
    chk32("unmapped", 32'h00000000, rdVal);
    wrap_up();
  end
endmodule : read_channel_control_reg_bench
`default_nettype wire

// >>> verilog/rcc_read_channel_control.sv
// Purpose: read channel control register with run/stop, soft reset and irq gating
// Assumes: register port is a simple write/read strobe on the register clock
// Notes: sys_rst synchronous active high; engine inputs are same-clock logic
//
// Overview of operation
// - run set starts channel, clears stopped flag
// - run cleared stops after current operation
// - descriptor updates finish before halted
// - stopped flag set once fully halted
// - channel error clears run bit
// - bit 1 reads one, ignores writes
// - writing bit 2 starts graceful soft reset
// - soft reset returns every register except read data to reset
// - soft reset bit reads one while busy
// - bit 3 selects fixed read address
// - bits 11..4 and 15 read zero
// - bit 12 gates completion interrupt
// - bit 13 gates timeout, ignored without descriptors
// - bit 14 gates error interrupt
// - threshold loads counter, zero raises interrupt
// - threshold write of zero is ignored
// - threshold ignored without descriptor mode
// - timeout count field, zero disables timer
`timescale 1ns/100ps
`default_nettype none
module rcc_read_channel_control
  import rcc_pkg::*;
#(
  parameter bit DESCRIPTOR_MODE_PARAM = 1'b1
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  input wire logic engineActive,
  input wire logic descUpdatePending,
  input wire logic channelError,
  input wire logic completionEvent,
  input wire logic packetEnd,
  input wire logic packetStart,
  input wire logic timeoutTick,
  input wire logic faultIrqFlag,
  input wire logic otherSoftReset,
  output logic runEnable,
  output logic haltedFlag,
  output logic fixedAddrMode,
  output logic softResetOut,
  output logic completionIrqFlag,
  output logic timeoutIrqFlag,
  output logic channelIrq
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic run;
    logic fixedAddr;
    logic cplEn;
    logic tmoEn;
    logic fltEn;
    logic [7:0] threshold;
    logic [7:0] timeout;
    rcc_run_t runState;
    logic srstBusy;
    logic [3:0] srstCount;
    logic [7:0] cplCount;
    logic cplFlag;
    logic [7:0] tmoCount;
    logic tmoArmed;
    logic tmoFlag;
    logic [31:0] rdata;
  } rcc_state_t;

  rcc_state_t state_reg;
  rcc_state_t state_next;

  function automatic logic [31:0] ctrl_word(input rcc_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[RCC_BIT_RUN] = s.run;
    w[RCC_BIT_RSVD_ONE] = 1'b1;
    w[RCC_BIT_SOFT_RESET] = s.srstBusy;
    w[RCC_BIT_FIXED_ADDR] = s.fixedAddr;
    w[RCC_BIT_CPL_EN] = s.cplEn;
    w[RCC_BIT_TMO_EN] = s.tmoEn;
    w[RCC_BIT_FLT_EN] = s.fltEn;
    w[RCC_THR_LSB +: 8] = s.threshold;
    w[RCC_TMO_LSB +: 8] = s.timeout;
    return w;
  endfunction : ctrl_word

  function automatic rcc_state_t reset_state();
    rcc_state_t s;
    s = '0;
    s.threshold = RCC_THR_RESET;
    s.timeout = RCC_TMO_RESET;
    s.runState = RCC_HALTED;
    s.cplCount = RCC_THR_RESET;
    return s;
  endfunction : reset_state

  logic ctrlWrite;
  logic srstStart;
  logic [7:0] wrThr;

  assign ctrlWrite = regWrite && (regAddr == RCC_CTRL_OFFSET);
  assign wrThr = regWdata[RCC_THR_LSB +: 8];
  assign srstStart = (ctrlWrite && regWdata[RCC_BIT_SOFT_RESET]) || otherSoftReset;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    state_next = state_reg;
    if (ctrlWrite && !state_reg.srstBusy)
    begin
      state_next.run = regWdata[RCC_BIT_RUN];
      state_next.fixedAddr = regWdata[RCC_BIT_FIXED_ADDR];
      state_next.cplEn = regWdata[RCC_BIT_CPL_EN];
      state_next.tmoEn = regWdata[RCC_BIT_TMO_EN];
      state_next.fltEn = regWdata[RCC_BIT_FLT_EN];
      state_next.timeout = regWdata[RCC_TMO_LSB +: 8];
      if (wrThr != 8'h00)
      begin
        state_next.threshold = wrThr;
        state_next.cplCount = wrThr;
      end
    end
    if (channelError)
    begin
      state_next.run = 1'b0;
    end
    // run/stop sequencing
    unique case (state_reg.runState)
      RCC_HALTED:
      begin
        if (state_reg.run && engineActive)
        begin
          state_next.runState = RCC_RUNNING;
        end
      end
      RCC_RUNNING:
      begin
        if (!state_reg.run)
        begin
          state_next.runState = RCC_STOPPING;
        end
      end
      RCC_STOPPING:
      begin
        // wait for the mover and the descriptor write-back queue to drain
        if (!engineActive && !(DESCRIPTOR_MODE_PARAM && descUpdatePending))
        begin
          state_next.runState = RCC_HALTED;
        end
      end
      default:
      begin
        state_next.runState = RCC_HALTED;
      end
    endcase
    // completion threshold counter
    if (DESCRIPTOR_MODE_PARAM && completionEvent)
    begin
      if (state_reg.cplCount <= 8'h01)
      begin
        state_next.cplFlag = 1'b1;
        state_next.cplCount = state_next.threshold;
      end
      else
      begin
        state_next.cplCount = state_reg.cplCount - 8'h01;
      end
    end
    else if (!DESCRIPTOR_MODE_PARAM && completionEvent)
    begin
      state_next.cplFlag = 1'b1;
    end
    // delay timer; packet end arms it, a new packet cancels it, zero timeout disables it
    if (packetStart || state_reg.timeout == 8'h00 || !DESCRIPTOR_MODE_PARAM)
    begin
      state_next.tmoArmed = 1'b0;
      state_next.tmoCount = 8'h00;
    end
    else if (packetEnd)
    begin
      state_next.tmoArmed = 1'b1;
      state_next.tmoCount = 8'h00;
    end
    else if (state_reg.tmoArmed && timeoutTick)
    begin
      if (state_reg.tmoCount + 8'h01 >= state_reg.timeout)
      begin
        state_next.tmoFlag = 1'b1;
        state_next.tmoArmed = 1'b0;
      end
      else
      begin
        state_next.tmoCount = state_reg.tmoCount + 8'h01;
      end
    end
    // soft reset sequencing
    if (state_reg.srstBusy)
    begin
      if (engineActive || descUpdatePending)
      begin
        state_next.srstCount = RCC_SRST_HOLD;
      end
      else if (state_reg.srstCount != 4'h0)
      begin
        state_next.srstCount = state_reg.srstCount - 4'h1;
      end
      else
      begin
        state_next = reset_state();
      end
    end
    else if (srstStart)
    begin
      state_next.srstBusy = 1'b1;
      state_next.srstCount = RCC_SRST_HOLD;
      state_next.run = 1'b0;
    end
    state_next.rdata = regRead ? ((regAddr == RCC_CTRL_OFFSET) ? ctrl_word(state_reg) : 32'h0000_0000)
                               : state_reg.rdata;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_reg <= reset_state();
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign regRdata = state_reg.rdata;
  assign runEnable = state_reg.run && !state_reg.srstBusy;
  assign haltedFlag = (state_reg.runState == RCC_HALTED);
  assign fixedAddrMode = state_reg.fixedAddr;
  assign softResetOut = state_reg.srstBusy;
  assign completionIrqFlag = state_reg.cplFlag;
  assign timeoutIrqFlag = state_reg.tmoFlag;
  // flags stay pending until a soft reset; the enables, plus descriptor mode for the timeout flag, gate the output
  assign channelIrq = (state_reg.cplFlag && state_reg.cplEn)
                    || (state_reg.tmoFlag && state_reg.tmoEn && DESCRIPTOR_MODE_PARAM)
                    || (faultIrqFlag && state_reg.fltEn);

  // ************************************************************
  // checks
  // ************************************************************
  a_error_stops_run: assert property (@(posedge clock) disable iff (sys_rst)
    channelError |=> !state_reg.run) else $error("run bit survived an error");
  a_halt_waits_queue: assert property (@(posedge clock) disable iff (sys_rst)
    (state_reg.runState == RCC_STOPPING && descUpdatePending && DESCRIPTOR_MODE_PARAM) |=> !haltedFlag)
    else $error("halted while descriptor updates pending");
  a_start_clears_halt: assert property (@(posedge clock) disable iff (sys_rst)
    (haltedFlag && state_reg.run && engineActive && !channelError) |=> !haltedFlag)
    else $error("halted flag did not clear on start");
  a_reserved_read: assert property (@(posedge clock) disable iff (sys_rst)
    $past(regRead) && $past(regAddr) == RCC_CTRL_OFFSET |-> regRdata[1] && regRdata[11:4] == 8'h00 && !regRdata[15])
    else $error("reserved bits read wrong");
  a_thr_never_zero: assert property (@(posedge clock) disable iff (sys_rst)
    state_reg.threshold != 8'h00) else $error("threshold holds zero");
  a_srst_visible: assert property (@(posedge clock) disable iff (sys_rst)
    (srstStart && !state_reg.srstBusy) |=> softResetOut) else $error("soft reset not flagged");
  a_srst_restores: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(softResetOut) |-> !state_reg.run && state_reg.threshold == RCC_THR_RESET && !state_reg.cplEn)
    else $error("soft reset left state");
  a_fault_gating: assert property (@(posedge clock) disable iff (sys_rst)
    (faultIrqFlag && state_reg.fltEn) |-> channelIrq) else $error("fault irq not raised");
  a_cpl_masked: assert property (@(posedge clock) disable iff (sys_rst)
    (!state_reg.cplEn && !(state_reg.tmoFlag && state_reg.tmoEn) && !(faultIrqFlag && state_reg.fltEn)) |-> !channelIrq)
    else $error("masked irq leaked");
  a_cpl_fires: assert property (@(posedge clock) disable iff (sys_rst)
    (DESCRIPTOR_MODE_PARAM && completionEvent && state_reg.cplCount == 8'h01 && !state_reg.srstBusy && !srstStart)
    |=> completionIrqFlag) else $error("threshold reached without flag");
  a_cpl_reload: assert property (@(posedge clock) disable iff (sys_rst)
    (DESCRIPTOR_MODE_PARAM && completionEvent && state_reg.cplCount == 8'h01 && !state_reg.srstBusy && !ctrlWrite)
    |=> state_reg.cplCount == $past(state_reg.threshold)) else $error("counter did not reload");
  a_run_clear_stops: assert property (@(posedge clock) disable iff (sys_rst)
    (state_reg.runState == RCC_RUNNING && !state_reg.run && !state_reg.srstBusy) |=> state_reg.runState == RCC_STOPPING)
    else $error("cleared run bit did not start stopping");
  a_stop_sets_halt: assert property (@(posedge clock) disable iff (sys_rst)
    (state_reg.runState == RCC_STOPPING && !engineActive && !descUpdatePending) |=> haltedFlag)
    else $error("halted flag late after drain");
  // zero timeout must never let the delay flag rise
  a_zero_tmo_off: assert property (@(posedge clock) disable iff (sys_rst)
    (state_reg.timeout == 8'h00 && !timeoutIrqFlag) |=> !timeoutIrqFlag)
    else $error("delay flag rose with zero timeout");
endmodule : rcc_read_channel_control
`default_nettype wire
